// file: src/fct_cfg.svh
`ifndef FCT_CFG_SVH
`define FCT_CFG_SVH

// ********************************
// table window and filler
// ********************************
`define FCT_BASE_OFS        8'h5C
`define FCT_LAST_OFS        8'h68
`define FCT_DEPTH           13
`define FCT_BLANK_BYTE      8'hFF

// ********************************
// instruction code entries
// ********************************
`define FCT_PRG_RESUME_OFS  8'h60
`define FCT_PRG_SUSPEND_OFS 8'h61
`define FCT_ERS_RESUME_OFS  8'h62
`define FCT_ERS_SUSPEND_OFS 8'h63
`define FCT_PRG_RESUME_VAL  8'h7A
`define FCT_PRG_SUSPEND_VAL 8'h75
`define FCT_ERS_RESUME_VAL  8'h7A
`define FCT_ERS_SUSPEND_VAL 8'h75

// ********************************
// suspend timing word fields
// ********************************
`define FCT_PRG_BAN_VAL     4'hC
`define FCT_ERS_BAN_VAL     4'hC
`define FCT_PRG_GAP_VAL     4'h0
`define FCT_PSUS_CNT_VAL    5'h15
`define FCT_PSUS_UNIT_VAL   2'h1
`define FCT_EGAP_CNT_VAL    4'hF
`define FCT_ESUS_CNT_VAL    5'h15
`define FCT_ESUS_UNIT_VAL   2'h1
`define FCT_SUSP_NOSUP_VAL  1'h0
`define FCT_RSVD_ONE        1'h1

// ********************************
// busy polling, power-down and four-wire mode fields
// ********************************
`define FCT_POLL_RSVD_VAL   2'h3
`define FCT_POLL_VAL        6'h3D
`define FCT_POLL_SR_BIT     2
`define FCT_POLL_FLAG_BIT   3
`define FCT_DSR_CNT_VAL     5'h02
`define FCT_DSR_UNIT_VAL    2'h1
`define FCT_DSR_CODE_VAL    8'hAB
`define FCT_DPD_CODE_VAL    8'hB9
`define FCT_DPD_NOSUP_VAL   1'h0
`define FCT_NO_CMD_CODE     8'hFF
`define FCT_QEXIT_VAL       4'h9
`define FCT_QENTER_VAL      4'h0

// ********************************
// opcodes the host drives
// ********************************
`define FCT_STATUS_RD_OP    8'h05
`define FCT_RST_EN_OP       8'h66
`define FCT_RST_OP          8'h99
`define FCT_QEXIT_FF_OP     8'hFF

// ********************************
// latency units, in ns
// ********************************
`define FCT_UNIT0_NS        32'h0000_0080
`define FCT_UNIT1_NS        32'h0000_03E8
`define FCT_UNIT2_NS        32'h0000_1F40
`define FCT_UNIT3_NS        32'h0000_FA00
`define FCT_GAP_UNIT_NS     32'h0000_FA00

// ********************************
// host command registers
// ********************************
`define FCT_H_CTRL_OFS      5'h00
`define FCT_H_STAT_OFS      5'h01
`define FCT_H_COPY_OFS      5'h10
`define FCT_H_START_BIT     0
`define FCT_H_CLR_BIT       1

`endif

// file: src/fct_pkg.sv
package fct_pkg;

  typedef logic [7:0]  fct_byte_t;
  typedef logic [31:0] fct_ns_t;

  typedef enum logic [3:0] {
    FCT_H_IDLE  = 4'b0001,
    FCT_H_ISSUE = 4'b0010,
    FCT_H_WAIT  = 4'b0100,
    FCT_H_DONE  = 4'b1000
  } fct_hstate_t;

endpackage

// file: src/fct_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fct_if;
  logic       rd_req;
  logic       wr_req;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;

  modport dev (
    input  rd_req,
    input  wr_req,
    input  addr,
    input  wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output rd_req,
    output wr_req,
    output addr,
    output wdata,
    input  rdata,
    input  rvalid
  );
endinterface

`default_nettype wire

// file: src/fct_table.sv
// Function
// - erase suspend latency count 10101b, unit 01b
// - erase resume-to-suspend count 1111b, times 64us
// - suspend supported bit reads 0
// - program resume code 7Ah advertised and used
// - program suspend code 75h advertised and used
// - erase resume code 7Ah advertised and used
// - erase suspend code 75h advertised and used
// - busy polling 111101b: poll bit0 via 05h
// - deep sleep release delay count 00010b, unit 01b
// - wake code 10101011b advertised and used
// - sleep entry code 10111001b advertised and used
// - deep power-down supported bit reads 0
// - four-wire exit 1001b: FFh or 66h/99h
// - program suspend latency count 10101b
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fct_cfg.svh"

module fct_table
  import fct_pkg::*;
#(
  parameter int DEPTH = `FCT_DEPTH
) (
  // clock and reset
  input  wire logic    clk_i,
  input  wire logic    rst_b_i,
  // link to the host
  fct_if.dev           link,
  // decoded timing for local use
  output fct_ns_t      ers_susp_max_ns_o,
  output fct_ns_t      prg_susp_max_ns_o,
  output fct_ns_t      ers_gap_ns_o,
  output fct_ns_t      dsr_max_ns_o,
  // write attempt seen
  output logic         wr_ignored_o
);

  // ********************************
  // unit decode
  // ********************************
  // one decoder serves every latency field with a unit code, so the unit codes agree everywhere; the erase gap uses FCT_GAP_UNIT_NS directly
  function automatic fct_ns_t unit_ns(input logic [1:0] code);
    fct_ns_t ns;
    ns = `FCT_UNIT0_NS;
    case (code)
      2'h0:    ns = `FCT_UNIT0_NS;
      2'h1:    ns = `FCT_UNIT1_NS;
      2'h2:    ns = `FCT_UNIT2_NS;
      2'h3:    ns = `FCT_UNIT3_NS;
      default: ns = `FCT_UNIT0_NS;
    endcase
    return ns;
  endfunction

  // ********************************
  // table words
  // ********************************
  // the three dwords and the mode byte are built from named fields so each field stays at its bit place
  wire logic [31:0] susp_word;
  wire logic [31:0] code_word;
  wire logic [31:0] pwr_word;
  wire logic [7:0]  qmode_byte;

  assign susp_word = {`FCT_SUSP_NOSUP_VAL,
                      `FCT_ESUS_UNIT_VAL,
                      `FCT_ESUS_CNT_VAL,
                      `FCT_EGAP_CNT_VAL,
                      `FCT_PSUS_UNIT_VAL,
                      `FCT_PSUS_CNT_VAL,
                      `FCT_PRG_GAP_VAL,
                      `FCT_RSVD_ONE,
                      `FCT_ERS_BAN_VAL,
                      `FCT_PRG_BAN_VAL};

  assign code_word = {`FCT_ERS_SUSPEND_VAL,
                      `FCT_ERS_RESUME_VAL,
                      `FCT_PRG_SUSPEND_VAL,
                      `FCT_PRG_RESUME_VAL};

  assign pwr_word  = {`FCT_DPD_NOSUP_VAL,
                      `FCT_DPD_CODE_VAL,
                      `FCT_DSR_CODE_VAL,
                      `FCT_DSR_UNIT_VAL,
                      `FCT_DSR_CNT_VAL,
                      `FCT_POLL_VAL,
                      `FCT_POLL_RSVD_VAL};

  assign qmode_byte = {`FCT_QENTER_VAL, `FCT_QEXIT_VAL};

  // ********************************
  // byte rom
  // ********************************
  // a larger DEPTH only repeats the mode byte; the listed table ends at 68h
  wire fct_byte_t rom_w [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_rom
      if (gi < 4) begin : g_susp
        assign rom_w[gi] = susp_word[gi*8 +: 8];
      end else if (gi < 8) begin : g_code
        assign rom_w[gi] = code_word[(gi-4)*8 +: 8];
      end else if (gi < 12) begin : g_pwr
        assign rom_w[gi] = pwr_word[(gi-8)*8 +: 8];
      end else begin : g_qmode
        assign rom_w[gi] = qmode_byte;
      end
    end
  endgenerate

  // ********************************
  // address decode
  // ********************************
  wire logic [7:0] rel_w;
  wire logic       in_range_w;
  wire fct_byte_t  rd_byte_w;

  // offsets are made relative first so the rom index stays four bits wide
  assign rel_w      = link.addr - `FCT_BASE_OFS;
  assign in_range_w = (link.addr >= `FCT_BASE_OFS) && (link.addr <= `FCT_LAST_OFS);
  // unlisted offsets answer with erased filler so a host scan never sees stale data
  assign rd_byte_w  = in_range_w ? rom_w[rel_w[3:0]] : `FCT_BLANK_BYTE;

  // ********************************
  // read answer
  // ********************************
  logic [7:0] rdata_r;
  logic       rvalid_r;
  logic       wr_ign_r;
  // rdata holds until the next read, so a slow host may still take it late

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= link.rd_req;
      if (link.rd_req) begin
        rdata_r <= rd_byte_w;
      end
    end
  end

  // writes land nowhere; only the attempt is reported
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ign_r <= 1'b0;
    end else begin
      wr_ign_r <= link.wr_req;
    end
  end

  // ********************************
  // link outputs
  // ********************************
  assign link.rdata   = rdata_r;
  assign link.rvalid  = rvalid_r;
  assign wr_ignored_o = wr_ign_r;

  // ********************************
  // decoded timing
  // ********************************
  wire fct_ns_t ers_susp_w;
  wire fct_ns_t prg_susp_w;
  wire fct_ns_t ers_gap_w;
  wire fct_ns_t dsr_w;

  // products of constants; flopping them keeps the outputs at zero in reset
  assign ers_susp_w = (32'({1'b0, `FCT_ESUS_CNT_VAL}) + 32'h0000_0001)
                      * unit_ns(`FCT_ESUS_UNIT_VAL);
  assign prg_susp_w = (32'({1'b0, `FCT_PSUS_CNT_VAL}) + 32'h0000_0001)
                      * unit_ns(`FCT_PSUS_UNIT_VAL);
  assign ers_gap_w  = (32'({1'b0, `FCT_EGAP_CNT_VAL}) + 32'h0000_0001)
                      * `FCT_GAP_UNIT_NS;
  assign dsr_w      = (32'({1'b0, `FCT_DSR_CNT_VAL}) + 32'h0000_0001)
                      * unit_ns(`FCT_DSR_UNIT_VAL);

  fct_ns_t ers_susp_r;
  fct_ns_t prg_susp_r;
  fct_ns_t ers_gap_r;
  fct_ns_t dsr_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ers_susp_r <= 32'h0000_0000;
      prg_susp_r <= 32'h0000_0000;
      ers_gap_r  <= 32'h0000_0000;
      dsr_r      <= 32'h0000_0000;
    end else begin
      ers_susp_r <= ers_susp_w;
      prg_susp_r <= prg_susp_w;
      ers_gap_r  <= ers_gap_w;
      dsr_r      <= dsr_w;
    end
  end

  assign ers_susp_max_ns_o = ers_susp_r;
  assign prg_susp_max_ns_o = prg_susp_r;
  assign ers_gap_ns_o      = ers_gap_r;
  assign dsr_max_ns_o      = dsr_r;

endmodule

`default_nettype wire

// file: src/fct_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fct_cfg.svh"

module fct_host
  import fct_pkg::*;
#(
  parameter int DEPTH = `FCT_DEPTH
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // link to the table
  fct_if.host             link,
  // software port
  input  wire logic [4:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // opcodes learnt from the table
  output logic      [7:0] prg_resume_op_o,
  output logic      [7:0] prg_suspend_op_o,
  output logic      [7:0] ers_resume_op_o,
  output logic      [7:0] ers_suspend_op_o,
  output logic      [7:0] dsr_op_o,
  output logic      [7:0] dpd_op_o,
  output logic      [7:0] poll_op_o,
  output logic      [7:0] qexit_op_o,
  output logic      [7:0] qexit_op2_o,
  output logic            qexit_two_o
);

  // ********************************
  // register decode
  // ********************************
  wire logic ctrl_wr_w;
  wire logic start_w;
  wire logic clr_w;
  wire logic copy_sel_w;

  assign ctrl_wr_w  = reg_wr_i && (reg_addr_i == `FCT_H_CTRL_OFS);
  assign start_w    = ctrl_wr_w && reg_wdata_i[`FCT_H_START_BIT];
  assign clr_w      = ctrl_wr_w && reg_wdata_i[`FCT_H_CLR_BIT];
  assign copy_sel_w = (reg_addr_i >= `FCT_H_COPY_OFS)
                      && (reg_addr_i < (`FCT_H_COPY_OFS + 5'(DEPTH)));

  // ********************************
  // fetch sequencer
  // ********************************
  fct_hstate_t state_r;
  fct_hstate_t state_nxt;
  logic [3:0]  idx_r;
  logic        done_r;
  fct_byte_t   copy_r [DEPTH];

  wire logic last_w;
  assign last_w = (idx_r == 4'(DEPTH - 1));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FCT_H_IDLE:  if (start_w) state_nxt = FCT_H_ISSUE;
      FCT_H_ISSUE: state_nxt = FCT_H_WAIT;
      FCT_H_WAIT:  if (link.rvalid) state_nxt = last_w ? FCT_H_DONE : FCT_H_ISSUE;
      FCT_H_DONE:  state_nxt = FCT_H_IDLE;
      default:     state_nxt = FCT_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= FCT_H_IDLE;
      idx_r   <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == FCT_H_IDLE) begin
        idx_r <= 4'h0;
      end else if ((state_r == FCT_H_WAIT) && link.rvalid && !last_w) begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  // completion wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_r <= 1'b0;
    end else if (state_r == FCT_H_DONE) begin
      done_r <= 1'b1;
    end else if (clr_w || start_w) begin
      done_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        copy_r[i] <= 8'h00;
      end
    end else if ((state_r == FCT_H_WAIT) && link.rvalid) begin
      copy_r[idx_r] <= link.rdata;
    end
  end

  // the host only reads; the table is never written
  assign link.rd_req = (state_r == FCT_H_ISSUE);
  assign link.addr   = `FCT_BASE_OFS + {4'h0, idx_r};
  assign link.wr_req = 1'b0;
  assign link.wdata  = 8'h00;

  // ********************************
  // software read port
  // ********************************
  wire logic [7:0] stat_w;
  wire logic [7:0] rd_mux_w;
  wire logic [4:0] copy_idx_w;
  logic [7:0]      rdata_r;

  assign copy_idx_w = reg_addr_i - `FCT_H_COPY_OFS;
  assign stat_w     = {3'h0,
                       copy_r[8][`FCT_POLL_SR_BIT],
                       ~copy_r[11][7],
                       ~copy_r[3][7],
                       done_r,
                       (state_r != FCT_H_IDLE)};
  assign rd_mux_w   = (reg_addr_i == `FCT_H_STAT_OFS) ? stat_w
                    : copy_sel_w ? copy_r[copy_idx_w[3:0]] : 8'h00;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_r <= rd_mux_w;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ********************************
  // opcodes from the table copy
  // ********************************
  wire logic [31:0] pwr_w;
  assign pwr_w = {copy_r[11], copy_r[10], copy_r[9], copy_r[8]};

  assign prg_resume_op_o  = copy_r[4];
  assign prg_suspend_op_o = copy_r[5];
  assign ers_resume_op_o  = copy_r[6];
  assign ers_suspend_op_o = copy_r[7];
  assign dsr_op_o         = pwr_w[22:15];
  assign dpd_op_o         = pwr_w[30:23];
  // busy is only ever polled through status bit 0; the flag-register path is unsupported
  assign poll_op_o        = copy_r[8][`FCT_POLL_SR_BIT] ? `FCT_STATUS_RD_OP : 8'h00;
  assign qexit_op_o       = copy_r[12][0] ? `FCT_QEXIT_FF_OP
                          : copy_r[12][3] ? `FCT_RST_EN_OP : 8'h00;
  assign qexit_two_o      = !copy_r[12][0] && copy_r[12][3];
  assign qexit_op2_o      = qexit_two_o ? `FCT_RST_OP : 8'h00;

endmodule

`default_nettype wire

// file: verif/fct_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module fct_monitor (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // link signals
  input  wire logic       rd_req,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // ********************************
  // link timing and table contents
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_rv_pulse;
    rd_req |=> rvalid;
  endproperty
  a_rv_pulse: assert property (p_rv_pulse) else $error("no answer after read");

  property p_no_rv;
    !rd_req |=> !rvalid;
  endproperty
  a_no_rv: assert property (p_no_rv) else $error("answer without read");

  property p_psus;
    rd_req && addr == 8'h5D |=> rdata == 8'hA1;
  endproperty
  a_psus: assert property (p_psus) else $error("byte 5D wrong");

  property p_susw;
    rd_req && (addr == 8'h5E || addr == 8'h5F) |=> rdata == ($past(addr[0]) ? 8'h35 : 8'hF6);
  endproperty
  a_susw: assert property (p_susw) else $error("suspend word wrong");

  property p_codes;
    rd_req && addr >= 8'h60 && addr <= 8'h63 |=> rdata == ($past(addr[0]) ? 8'h75 : 8'h7A);
  endproperty
  a_codes: assert property (p_codes) else $error("suspend code wrong");

  property p_poll;
    rd_req && addr == 8'h64 |=> rdata == 8'hF7;
  endproperty
  a_poll: assert property (p_poll) else $error("poll byte wrong");

  property p_dsr;
    rd_req && addr >= 8'h65 && addr <= 8'h67 |=>
      rdata == ($past(addr) == 8'h65 ? 8'hA2 : ($past(addr) == 8'h66 ? 8'hD5 : 8'h5C));
  endproperty
  a_dsr: assert property (p_dsr) else $error("power-down word wrong");

  property p_qexit;
    rd_req && addr == 8'h68 |=> rdata == 8'h09;
  endproperty
  a_qexit: assert property (p_qexit) else $error("exit byte wrong");

  // the host walks the table one byte every second cycle
  property p_host_seq;
    rd_req && addr != 8'h68 |=> !rd_req ##1 (rd_req && addr == $past(addr, 2) + 8'h01);
  endproperty
  a_host_seq: assert property (p_host_seq) else $error("host read order wrong");

  property p_host_rng;
    rd_req |-> addr >= 8'h5C && addr <= 8'h68;
  endproperty
  a_host_rng: assert property (p_host_rng) else $error("host read outside table");
endmodule

`default_nettype wire

// file: verif/flash_capability_table_tb.sv
`timescale 1ns/1ps
`default_nettype none

module flash_capability_table_tb import fct_pkg::*; ;
  // ********************************
  // signals and instances
  // ********************************
  logic       clk_i;
  logic       rst_b_i;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] rdata_o;
  logic [7:0] op_pr, op_ps, op_er, op_es, op_dsr, op_dpd, op_poll, op_qx, op_qx2;
  logic       qx_two;
  fct_ns_t    t_es, t_ps, t_gap, t_dsr;
  logic       wr_ign;
  int         fails;
  int         n_compared;
  localparam fct_byte_t EXP [13] = '{8'hCC, 8'hA1, 8'hF6, 8'h35, 8'h7A, 8'h75, 8'h7A,
                                     8'h75, 8'hF7, 8'hA2, 8'hD5, 8'h5C, 8'h09};

  fct_if link1 ();
  // second link lets the bench break the host's side on purpose
  fct_if link2 ();

  fct_table fct_table_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link1),
    .ers_susp_max_ns_o(t_es), .prg_susp_max_ns_o(t_ps), .ers_gap_ns_o(t_gap),
    .dsr_max_ns_o(t_dsr), .wr_ignored_o());
  fct_table fct_table_inst_2 (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link2),
    .ers_susp_max_ns_o(), .prg_susp_max_ns_o(), .ers_gap_ns_o(),
    .dsr_max_ns_o(), .wr_ignored_o(wr_ign));
  fct_host fct_host_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link1),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata_o), .prg_resume_op_o(op_pr), .prg_suspend_op_o(op_ps),
    .ers_resume_op_o(op_er), .ers_suspend_op_o(op_es), .dsr_op_o(op_dsr),
    .dpd_op_o(op_dpd), .poll_op_o(op_poll), .qexit_op_o(op_qx), .qexit_op2_o(op_qx2),
    .qexit_two_o(qx_two));
  fct_monitor fct_monitor_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .rd_req(link1.rd_req),
    .addr(link1.addr), .rdata(link1.rdata), .rvalid(link1.rvalid));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ********************************
  // shared tasks
  // ********************************
  task automatic end_of_test;
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk8(input fct_byte_t got, input fct_byte_t exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk32(input fct_ns_t got, input fct_ns_t exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %0d want %0d", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_i);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_i);
    reg_rd <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic dev_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    link2.rd_req <= 1'b1;
    link2.addr <= a;
    @(posedge clk_i);
    link2.rd_req <= 1'b0;
    #1 chk8({7'h00, link2.rvalid}, 8'h01, "rvalid");
    d = link2.rdata;
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_timing;
    chk32(t_es, 32'h0000_55F0, "erase suspend ns");
    chk32(t_ps, 32'h0000_55F0, "program suspend ns");
    chk32(t_gap, 32'h000F_A000, "resume gap ns");
    chk32(t_dsr, 32'h0000_0BB8, "release delay ns");
  endtask

  task automatic t_fetch;
    logic [7:0] s;
    int n;
    chk8(op_pr, 8'h00, "opcode before fetch");
    reg_write(5'h00, 8'h01);
    // a second start while busy must not restart the walk
    reg_write(5'h00, 8'h01);
    reg_read(5'h01, s);
    chk8(s & 8'h01, 8'h01, "busy");
    n = 0;
    while (s[1] !== 1'b1 && n < 100) begin
      reg_read(5'h01, s);
      n++;
    end
    if (n == 100) begin
      fails++;
      end_of_test();
    end
    chk8(s & 8'h1F, 8'h1E, "status after fetch");
  endtask

  task automatic t_regs;
    logic [7:0] s;
    reg_write(5'h00, 8'h02);
    reg_read(5'h01, s);
    chk8(s & 8'h02, 8'h00, "done cleared");
    reg_read(5'h00, s);
    chk8(s, 8'h00, "control reads zero");
    reg_write(5'h05, 8'hAA);
    reg_read(5'h05, s);
    chk8(s, 8'h00, "unmapped register");
    for (int i = 0; i < 13; i++) begin
      reg_read(5'h10 + 5'(i), s);
      chk8(s, EXP[i], "table copy");
    end
  endtask

  task automatic t_ops;
    chk8(op_pr, 8'h7A, "program resume op");
    chk8(op_ps, 8'h75, "program suspend op");
    chk8(op_er, 8'h7A, "erase resume op");
    chk8(op_es, 8'h75, "erase suspend op");
    chk8(op_poll, 8'h05, "poll op");
    chk8(op_dsr, 8'hAB, "wake op");
    chk8(op_dpd, 8'hB9, "sleep op");
    chk8(op_qx, 8'hFF, "four wire exit op");
    chk8(op_qx2, 8'h00, "no second exit op");
    chk8({7'h00, qx_two}, 8'h00, "single exit step");
  endtask

  task automatic t_dev;
    logic [7:0] d;
    @(posedge clk_i);
    link2.wr_req <= 1'b1;
    link2.addr <= 8'h60;
    link2.wdata <= 8'h00;
    @(posedge clk_i);
    link2.wr_req <= 1'b0;
    #1 chk8({7'h00, wr_ign}, 8'h01, "write seen");
    dev_read(8'h60, d);
    chk8(d, 8'h7A, "byte after write");
    dev_read(8'h20, d);
    chk8(d, 8'hFF, "outside table");
    // reads on every cycle, each answer checked one edge later
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_i);
      link2.rd_req <= (i < 13);
      link2.addr <= 8'h5C + 8'(i);
      #1 if (i > 0) chk8(link2.rdata, EXP[i-1], "streamed byte");
    end
  endtask

  task automatic t_rst;
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk8(op_pr, 8'h00, "opcode in reset");
    chk32(t_es, 32'h0, "timing in reset");
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_timing();
  endtask

  initial begin
    rst_b_i = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    link2.rd_req = 1'b0;
    link2.wr_req = 1'b0;
    link2.addr = 8'h00;
    link2.wdata = 8'h00;
    fails = 0;
    n_compared = 0;
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    t_timing();
    t_fetch();
    t_ops();
    t_regs();
    t_dev();
    t_rst();
    end_of_test();
  end
endmodule

`default_nettype wire
